// *** rtl/sdm_module_core.sv ***
// Operation
// - Sample all inputs on rising clock edge.
// - Deselected chip ignores all but enable, masks.
// - Low clock enable freezes on its own edge.
// - Row twelve bits, column nine bits, shared.
// - Bank lines pick bank at row, column.
// - Row strobe low latches row address.
// - Column strobe low latches column, starts access.
// - Write data captured from write command edge.
// - Lane mask blocks write, floats read lane.
// - New column accepted every clock cycle.
// - Cut read trails two words CL3, one CL2.
`timescale 1ns/1ps
`default_nettype none
`include "sdm_defines.svh"
module sdm_module_core #(
  parameter int MEM_DEPTH = `SDM_MEM_DEPTH
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic srst,
  // Command pins.
  input wire logic clockEnable,
  input wire logic chipSelectN,
  input wire logic rowStrobeN,
  input wire logic columnStrobeN,
  input wire logic writeEnableN,
  input wire logic [`SDM_BANK_W-1:0] bank_select,
  input wire logic [`SDM_ROW_W-1:0] muxed_address,
  input wire logic [`SDM_LANES-1:0] byte_lane_mask,
  // Data pins, split into three signals; enable low drives.
  input wire logic [`SDM_DATA_W-1:0] dataBusIn,
  output logic [`SDM_DATA_W-1:0] dataBusOut,
  output logic [`SDM_LANES-1:0] dataBusOeN,
  // Read receiver back-pressure and open-bank status.
  input wire logic readReady,
  output logic readValid,
  output logic [`SDM_BANK_W-1:0] lastBank,
  output logic powerDown
);
  localparam int AW = $clog2(MEM_DEPTH);
  // ==========================================
  // Parameter checks.
  // The index is a plain slice of the column, so only powers of two are served.
  if (MEM_DEPTH < 2 || MEM_DEPTH > (1 << `SDM_COL_W)) begin : gDepthRange
    $error("MEM_DEPTH out of range");
  end
  if ((MEM_DEPTH & (MEM_DEPTH - 1)) != 0) begin : gDepthPow2
    $error("MEM_DEPTH must be a power of two");
  end
  // ==========================================
  // Command decode.
  // A low clock enable masks the command on its own edge and holds the read pipe still.
  wire active = clockEnable;
  wire selected = active && !chipSelectN;
  wire [2:0] strobes = {rowStrobeN, columnStrobeN, writeEnableN};
  sdm_pkg::sdm_cmd_e cmd;
  assign cmd = !selected ? sdm_pkg::CMD_NOP :
    sdm_pkg::sdm_cmd_e'(strobes == 3'b011 ? 3'h1 :
    strobes == 3'b101 ? 3'h2 :
    strobes == 3'b100 ? 3'h3 :
    strobes == 3'b010 ? 3'h4 :
    strobes == 3'b001 ? 3'h5 :
    strobes == 3'b110 ? 3'h6 :
    strobes == 3'b000 ? 3'h7 : 3'h0);
  wire isAct = (cmd == sdm_pkg::CMD_ACT);
  wire isRd = (cmd == sdm_pkg::CMD_RD);
  wire isWr = (cmd == sdm_pkg::CMD_WR);
  wire isPre = (cmd == sdm_pkg::CMD_PRE);
  wire isStop = (cmd == sdm_pkg::CMD_STOP);
  wire isMrs = (cmd == sdm_pkg::CMD_MRS);
  // ==========================================
  // Bank, row and mode state.
  logic [3:0] bankOpen_q;
  logic [`SDM_ROW_W-1:0] openRow_q [4];
  logic [2:0] casLat_q;
  logic [2:0] burstLen_q;
  logic [`SDM_BANK_W-1:0] lastBank_q;
  logic powerDown_q;
  wire [`SDM_COL_W-1:0] colAddr = muxed_address[`SDM_COL_W-1:0];
  wire [AW-1:0] memIdx = colAddr[AW-1:0];
  wire [2:0] trailLoad = (casLat_q == 3'h3) ? 3'(`SDM_TRAIL_CL3) : 3'(`SDM_TRAIL_CL2);
  always_ff @(posedge clk) begin
    if (srst) begin
      bankOpen_q <= 4'h0;
      casLat_q <= `SDM_RST_CL;
      burstLen_q <= `SDM_RST_BL;
      lastBank_q <= 2'h0;
      powerDown_q <= 1'b0;
    end else begin
      powerDown_q <= !clockEnable && (bankOpen_q == 4'h0);
      if (isAct) begin
        bankOpen_q[bank_select] <= 1'b1;
        openRow_q[bank_select] <= muxed_address;
        lastBank_q <= bank_select;
      end
      if (isPre) begin
        if (muxed_address[10]) bankOpen_q <= 4'h0;
        else bankOpen_q[bank_select] <= 1'b0;
      end
      if (isRd || isWr) lastBank_q <= bank_select;
      if (isMrs) begin
        casLat_q <= muxed_address[`SDM_MODE_CL_LSB +: 3];
        burstLen_q <= muxed_address[`SDM_MODE_BL_LSB +: 3];
      end
    end
  end
  // ==========================================
  // Storage; writes land the same edge as the column command.
  // The bank is ignored here, so a small array stands in for the whole module.
  logic [`SDM_DATA_W-1:0] mem_q [MEM_DEPTH];
  wire [`SDM_LANES-1:0] laneWrite = {`SDM_LANES{isWr}} & ~byte_lane_mask;
  always_ff @(posedge clk) begin
    for (int l = 0; l < `SDM_LANES; l++) begin
      if (laneWrite[l]) mem_q[memIdx][l*8 +: 8] <= dataBusIn[l*8 +: 8];
    end
  end
  // ==========================================
  // Read path; a read may issue every cycle, so the pipe is a shift line.
  logic [7:0] rdPipe_q;
  logic [AW-1:0] rdIdx_q [8];
  logic [2:0] trail_q;
  wire cutRead = isPre || isStop;
  always_ff @(posedge clk) begin
    if (srst) begin
      rdPipe_q <= 8'h0;
      trail_q <= 3'h0;
    end else if (active) begin
      rdPipe_q <= {rdPipe_q[6:0], isRd};
      if (cutRead && rdPipe_q != 8'h0) trail_q <= trailLoad;
      else if (trail_q != 3'h0) trail_q <= trail_q - 3'h1;
    end
  end
  always_ff @(posedge clk) begin
    if (active) begin
      rdIdx_q[0] <= memIdx;
      for (int i = 1; i < 8; i++) rdIdx_q[i] <= rdIdx_q[i-1];
    end
  end
  wire [2:0] tap = casLat_q - 3'h1;
  wire rdDue = active && rdPipe_q[tap];
  sdm_pkg::sdm_word_s rdWord;
  sdm_pkg::sdm_word_s bufWord;
  assign rdWord.data = mem_q[rdIdx_q[tap]];
  assign rdWord.laneMask = byte_lane_mask;
  logic bufValid;
  // A further read while two words wait is dropped; the receiver must not stall that long.
  sdm_skid_buf #(.WIDTH($bits(sdm_pkg::sdm_word_s))) uBuf (
    .clk(clk),
    .srst(srst),
    .inValid(rdDue),
    .inReady(),
    .inData(rdWord),
    .outValid(bufValid),
    .outReady(readReady),
    .outData(bufWord)
  );
  // ==========================================
  // Output registers; a masked lane floats.
  // Registering the pins costs a cycle of latency but keeps every output free of glitches.
  logic [`SDM_DATA_W-1:0] dOut_q;
  logic [`SDM_LANES-1:0] oeN_q;
  logic rdValid_q;
  always_ff @(posedge clk) begin
    if (srst) begin
      dOut_q <= 64'h0;
      oeN_q <= 8'hff;
      rdValid_q <= 1'b0;
    end else begin
      rdValid_q <= bufValid && readReady;
      dOut_q <= bufWord.data;
      oeN_q <= (bufValid && readReady) ? bufWord.laneMask : 8'hff;
    end
  end
  assign dataBusOut = dOut_q;
  assign dataBusOeN = oeN_q;
  assign readValid = rdValid_q;
  assign lastBank = lastBank_q;
  assign powerDown = powerDown_q;
  // ==========================================
  // Checks.
  ignored_desel_a: assert property (@(posedge clk) disable iff (srst)
    (active && chipSelectN && strobes == 3'b101) |=> !rdPipe_q[0]) else $error("deselected read");
  freeze_a: assert property (@(posedge clk) disable iff (srst)
    !clockEnable |=> $stable(rdPipe_q) && $stable(trail_q)) else $error("freeze broken");
  act_opens_a: assert property (@(posedge clk) disable iff (srst)
    isAct |=> bankOpen_q[$past(bank_select)]) else $error("bank not opened");
  trail_cl3_a: assert property (@(posedge clk) disable iff (srst)
    (cutRead && active && rdPipe_q != 8'h0 && casLat_q == 3'h3) |=> trail_q == 3'(`SDM_TRAIL_CL3))
    else $error("trail");
  pipe_a: assert property (@(posedge clk) disable iff (srst)
    (isRd ##1 clockEnable) |-> rdPipe_q[0]) else $error("read lost");
  mask_float_a: assert property (@(posedge clk) disable iff (srst)
    !rdValid_q |-> oeN_q == 8'hff) else $error("driving idle");
  mrs_a: assert property (@(posedge clk) disable iff (srst)
    isMrs |=> casLat_q == $past(muxed_address[6:4])) else $error("mode");
  pd_a: assert property (@(posedge clk) disable iff (srst)
    (!clockEnable && bankOpen_q == 4'h0) |=> powerDown_q) else $error("power down");
  wr_lands_a: assert property (@(posedge clk) disable iff (srst)
    laneWrite[0] |=> mem_q[$past(memIdx)][7:0] == $past(dataBusIn[7:0])) else $error("write lost");
  mask_keeps_a: assert property (@(posedge clk) disable iff (srst)
    (isWr && byte_lane_mask[0]) |=> mem_q[$past(memIdx)][7:0] == $past(mem_q[memIdx][7:0])) else $error("mask");
  desel_write_a: assert property (@(posedge clk) disable iff (srst)
    (!selected && strobes == 3'b100) |=> mem_q[$past(memIdx)] == $past(mem_q[memIdx])) else $error("desel");
  pre_all_a: assert property (@(posedge clk) disable iff (srst)
    (isPre && muxed_address[10]) |=> bankOpen_q == 4'h0) else $error("banks left open");
  act_row_a: assert property (@(posedge clk) disable iff (srst)
    isAct |=> openRow_q[$past(bank_select)] == $past(muxed_address)) else $error("row not latched");
  last_bank_a: assert property (@(posedge clk) disable iff (srst)
    (isRd || isWr) |=> lastBank_q == $past(bank_select)) else $error("column bank");
  burst_len_a: assert property (@(posedge clk) disable iff (srst)
    isMrs |=> burstLen_q == $past(muxed_address[2:0])) else $error("burst length");
endmodule
`default_nettype wire

// *** rtl/sdm_defines.svh ***
`ifndef SDM_DEFINES_SVH
`define SDM_DEFINES_SVH
// ==========================================
// Geometry.
`define SDM_ROW_W 12
`define SDM_COL_W 9
`define SDM_BANK_W 2
`define SDM_DATA_W 64
`define SDM_LANES 8
// ==========================================
// Mode word fields on the address lines.
`define SDM_MODE_BL_LSB 0
`define SDM_MODE_CL_LSB 4
`define SDM_RST_CL 3'h3
`define SDM_RST_BL 3'h0
// ==========================================
// Read data may trail a burst cut short.
`define SDM_TRAIL_CL3 2
`define SDM_TRAIL_CL2 1
`define SDM_MEM_DEPTH 16
`endif

// *** rtl/sdm_pkg.sv ***
package sdm_pkg;
  typedef enum logic [2:0] {
    CMD_NOP = 3'h0,
    CMD_ACT = 3'h1,
    CMD_RD = 3'h2,
    CMD_WR = 3'h3,
    CMD_PRE = 3'h4,
    CMD_REF = 3'h5,
    CMD_STOP = 3'h6,
    CMD_MRS = 3'h7
  } sdm_cmd_e;
  typedef struct packed {
    logic [63:0] data;
    logic [7:0] laneMask;
  } sdm_word_s;
endpackage

// *** rtl/sdm_skid_buf.sv ***
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// Two-entry buffer; a stalled drain never loses a word.
module sdm_skid_buf #(
  parameter int WIDTH = 72
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic srst,
  // Fill side.
  input wire logic inValid,
  output logic inReady,
  input wire logic [WIDTH-1:0] inData,
  // Drain side.
  output logic outValid,
  input wire logic outReady,
  output logic [WIDTH-1:0] outData
);
  if (WIDTH < 1) begin : gWidthCheck
    $error("WIDTH must be positive");
  end
  logic [WIDTH-1:0] mem_q [2];
  logic wrPtr_q;
  logic rdPtr_q;
  logic [1:0] count_q;
  wire doPush = inValid && inReady;
  wire doPop = outValid && outReady;
  assign inReady = (count_q != 2'h2);
  assign outValid = (count_q != 2'h0);
  assign outData = mem_q[rdPtr_q];
  always_ff @(posedge clk) begin
    if (srst) begin
      wrPtr_q <= 1'b0;
      rdPtr_q <= 1'b0;
      count_q <= 2'h0;
    end else begin
      if (doPush) wrPtr_q <= ~wrPtr_q;
      if (doPop) rdPtr_q <= ~rdPtr_q;
      count_q <= count_q + {1'b0, doPush} - {1'b0, doPop};
    end
  end
  always_ff @(posedge clk) begin
    if (doPush) mem_q[wrPtr_q] <= inData;
  end
endmodule
`default_nettype wire

// *** dv/sdm_ctrl_model.sv ***
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// Far-side controller.
// Pins move only at the falling edge, so the block never sees a change near its sampling edge.
module sdm_ctrl_model (
  // Clock.
  input wire logic clk,
  // Command pins.
  output logic clockEnable,
  output logic chipSelectN,
  output logic rowStrobeN,
  output logic columnStrobeN,
  output logic writeEnableN,
  output logic [1:0] bank_select,
  output logic [11:0] muxed_address,
  output logic [7:0] byte_lane_mask,
  // Write data.
  output logic [63:0] dataBusIn
);
  localparam logic [2:0] ENC [0:7] = '{3'h7, 3'h3, 3'h5, 3'h4, 3'h2, 3'h1, 3'h6, 3'h0};
  initial begin
    {clockEnable, chipSelectN, rowStrobeN, columnStrobeN, writeEnableN} = 5'h1f;
    bank_select = 2'h0;
    muxed_address = 12'h000;
    byte_lane_mask = 8'h00;
    dataBusIn = 64'h0;
  end
  task automatic go(input sdm_pkg::sdm_cmd_e c, input logic [1:0] b, input logic [11:0] a,
      input logic [63:0] d, input logic [7:0] m, input logic en, input logic sel);
    @(negedge clk);
    clockEnable = en;
    chipSelectN = ~sel;
    {rowStrobeN, columnStrobeN, writeEnableN} = ENC[c];
    bank_select = b;
    muxed_address = a;
    byte_lane_mask = m;
    // Released data toggles so a stale word is never mistaken for a fresh one.
    dataBusIn = (c == sdm_pkg::CMD_WR) ? d : ~dataBusIn;
  endtask
endmodule
`default_nettype wire

// *** dv/sdm_module_core_tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none
module sdm_module_core_tb_top;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic readReady = 1'b1;
  logic clockEnable, chipSelectN, rowStrobeN, columnStrobeN, writeEnableN, readValid, powerDown;
  logic [1:0] bank_select, lastBank;
  logic [11:0] muxed_address;
  logic [7:0] byte_lane_mask, dataBusOeN;
  logic [63:0] dataBusIn, dataBusOut;
  int err_total = 0;
  int check_count = 0;
  localparam logic [63:0] W1 = {{4{8'h22}}, {4{8'h11}}};
  always #2.5 clk = ~clk;
  sdm_ctrl_model u_sdm_ctrl_model (.clk(clk), .clockEnable(clockEnable), .chipSelectN(chipSelectN),
    .rowStrobeN(rowStrobeN), .columnStrobeN(columnStrobeN), .writeEnableN(writeEnableN),
    .bank_select(bank_select), .muxed_address(muxed_address), .byte_lane_mask(byte_lane_mask),
    .dataBusIn(dataBusIn));
  sdm_module_core u_sdm_module_core (.clk(clk), .srst(srst), .clockEnable(clockEnable),
    .chipSelectN(chipSelectN), .rowStrobeN(rowStrobeN), .columnStrobeN(columnStrobeN),
    .writeEnableN(writeEnableN), .bank_select(bank_select), .muxed_address(muxed_address),
    .byte_lane_mask(byte_lane_mask), .dataBusIn(dataBusIn), .dataBusOut(dataBusOut),
    .dataBusOeN(dataBusOeN), .readReady(readReady), .readValid(readValid), .lastBank(lastBank),
    .powerDown(powerDown));
  // ==========================================
  // Helpers.
  task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
    check_count++;
    if (got !== exp) begin
      err_total++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic cmd(input sdm_pkg::sdm_cmd_e c, input logic [11:0] a, input logic [63:0] d = 64'h0,
      input logic [7:0] m = 8'h00, input logic en = 1'b1, input logic sel = 1'b1, input logic [1:0] b = 2'h0);
    u_sdm_ctrl_model.go(c, b, a, d, m, en, sel);
  endtask
  task automatic get_word(input logic [63:0] exp, input logic [7:0] m, input int lat);
    int k;
    k = 0;
    while (readValid !== 1'b1 && k < 12) begin
      @(posedge clk);
      #1;
      k++;
    end
    if (lat > 0) chk("latency", 64'(lat), 64'(k));
    if (m == 8'h00) chk("read data", exp, dataBusOut);
    chk("lane enable", 64'(m), 64'(dataBusOeN));
  endtask
  task automatic rd(input logic [11:0] col, input logic [7:0] m, input logic [63:0] exp, input int lat);
    cmd(sdm_pkg::CMD_RD, col, 64'h0, m);
    cmd(sdm_pkg::CMD_NOP, 12'h000, 64'h0, m);
    get_word(exp, m, lat);
  endtask
  // ==========================================
  // Scenarios.
  task automatic t_write_mask();
    cmd(sdm_pkg::CMD_WR, 12'h001, {8{8'h11}});
    cmd(sdm_pkg::CMD_WR, 12'h001, {8{8'h22}}, 8'h0f);
    cmd(sdm_pkg::CMD_WR, 12'h002, {8{8'h33}});
    cmd(sdm_pkg::CMD_NOP, 12'h000);
    cmd(sdm_pkg::CMD_STOP, 12'h000);
    cmd(sdm_pkg::CMD_NOP, 12'h000);
    rd(12'h001, 8'h00, W1, 4);
    $display("test write_mask done");
  endtask
  task automatic t_refused();
    cmd(sdm_pkg::CMD_RD, 12'h001, 64'h0, 8'h00, 1'b1, 1'b0);
    cmd(sdm_pkg::CMD_WR, 12'h002, 64'h0, 8'h00, 1'b1, 1'b0);
    cmd(sdm_pkg::CMD_WR, 12'h002, 64'h0, 8'h00, 1'b0);
    cmd(sdm_pkg::CMD_NOP, 12'h000);
    rd(12'h002, 8'h00, {8{8'h33}}, 4);
    rd(12'h002, 8'hf0, 64'h0, 4);
    $display("test refused done");
  endtask
  task automatic t_stall();
    @(negedge clk);
    readReady = 1'b0;
    cmd(sdm_pkg::CMD_RD, 12'h001);
    cmd(sdm_pkg::CMD_RD, 12'h002);
    cmd(sdm_pkg::CMD_NOP, 12'h000);
    repeat (8) @(posedge clk);
    #1;
    chk("stalled valid", 64'h0, 64'(readValid));
    @(negedge clk);
    readReady = 1'b1;
    get_word(W1, 8'h00, 0);
    @(posedge clk);
    #1;
    get_word({8{8'h33}}, 8'h00, 0);
    $display("test stall done");
  endtask
  task automatic t_latency();
    cmd(sdm_pkg::CMD_MRS, 12'h020);
    rd(12'h001, 8'h00, W1, 3);
    cmd(sdm_pkg::CMD_MRS, 12'h030);
    rd(12'h001, 8'h00, W1, 4);
    cmd(sdm_pkg::CMD_RD, 12'h002);
    cmd(sdm_pkg::CMD_STOP, 12'h000);
    get_word({8{8'h33}}, 8'h00, 4);
    $display("test latency done");
  endtask
  task automatic t_power();
    cmd(sdm_pkg::CMD_PRE, 12'h400);
    repeat (4) cmd(sdm_pkg::CMD_NOP, 12'h000);
    cmd(sdm_pkg::CMD_REF, 12'h000);
    repeat (14) cmd(sdm_pkg::CMD_NOP, 12'h000);
    repeat (3) cmd(sdm_pkg::CMD_NOP, 12'h000, 64'h0, 8'h00, 1'b0);
    chk("standby", 64'h1, 64'(powerDown));
    cmd(sdm_pkg::CMD_NOP, 12'h000);
    cmd(sdm_pkg::CMD_ACT, 12'h123, 64'h0, 8'h00, 1'b1, 1'b1, 2'h2);
    cmd(sdm_pkg::CMD_NOP, 12'h000);
    chk("open bank", 64'h2, 64'(lastBank));
    repeat (3) cmd(sdm_pkg::CMD_NOP, 12'h000, 64'h0, 8'h00, 1'b0);
    chk("active standby", 64'h0, 64'(powerDown));
    $display("test power done");
  endtask
  task automatic complete_run();
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  initial begin
    repeat (2) @(posedge clk);
    #1;
    chk("reset lanes", 64'hff, 64'(dataBusOeN));
    chk("reset valid", 64'h0, 64'(readValid));
    @(negedge clk);
    srst = 1'b0;
    cmd(sdm_pkg::CMD_MRS, 12'h030);
    cmd(sdm_pkg::CMD_ACT, 12'habc);
    repeat (4) cmd(sdm_pkg::CMD_NOP, 12'h000);
    t_write_mask();
    t_refused();
    t_stall();
    t_latency();
    t_power();
    complete_run();
  end
  initial begin
    repeat (5000) @(posedge clk);
    err_total++;
    complete_run();
  end
endmodule
`default_nettype wire
